// ---- inc/burst_sram_params.svh ----
// widths, counts and reset values of the split-port burst memory
`ifndef BURST_SRAM_PARAMS_SVH
`define BURST_SRAM_PARAMS_SVH

`define BSR_DATA_W     18
`define BSR_ADDR_W     19
`define BSR_LANE_W     9
`define BSR_LANES      2
`define BSR_BEATS      4
`define BSR_AGE_DEPTH  4
`define BSR_WORD_RST   18'h00000
`define BSR_ADDR_RST   19'h00000
`define BSR_SEL_RST    2'h3

`endif

// ---- inc/burst_sram_pkg.sv ----
// types shared by the burst memory modules
`include "burst_sram_params.svh"

package burst_sram_pkg;
    typedef logic [`BSR_DATA_W-1:0]  word_t;
    typedef logic [`BSR_ADDR_W-1:0]  addr_t;
    typedef logic [`BSR_LANES-1:0]   lane_sel_t;
    typedef word_t [`BSR_BEATS-1:0]  burst_t;
    typedef lane_sel_t [`BSR_BEATS-1:0] burst_sel_t;
endpackage

// ---- inc/store_port_if.sv ----
// core-side port between the link logic and the burst storage
`timescale 1ns/10ps

interface store_port_if;
    logic                    wr_req;
    burst_sram_pkg::addr_t   wr_addr;
    burst_sram_pkg::burst_t  wr_data;
    burst_sram_pkg::burst_sel_t wr_sel_n;
    logic                    rd_req;
    burst_sram_pkg::addr_t   rd_addr;
    burst_sram_pkg::burst_t  rd_data;

    modport ctrl (
        output wr_req, wr_addr, wr_data, wr_sel_n, rd_req, rd_addr,
        input  rd_data
    );
    modport store (
        input  wr_req, wr_addr, wr_data, wr_sel_n, rd_req, rd_addr,
        output rd_data
    );
endinterface

// ---- rtl/event_crossing.sv ----
// toggle-to-pulse crossing into the destination clock domain
`timescale 1ns/10ps

module event_crossing (
    input  wire logic dst_clk_in,
    input  wire logic rst_in,
    input  wire logic toggle_in,
    output logic      pulse_out
);
    logic meta_r;
    logic stable_r;
    logic last_r;

    // meta_r feeds only stable_r; the edge is taken from the later stages
    always_ff @(posedge dst_clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_r   <= 1'b0;
            stable_r <= 1'b0;
            last_r   <= 1'b0;
        end else begin
            meta_r   <= toggle_in;
            stable_r <= meta_r;
            last_r   <= stable_r;
        end
    end

    assign pulse_out = stable_r ^ last_r;
endmodule // event_crossing

// ---- rtl/burst_store.sv ----
// burst-wide storage array with per-lane write gating
`timescale 1ns/10ps
`include "burst_sram_params.svh"

module burst_store (
    input  wire logic   core_clk_in,
    input  wire logic   rst_in,
    store_port_if.store port_io
);
    localparam int DEPTH   = 1 << `BSR_ADDR_W;
    localparam int NLANES  = `BSR_BEATS * `BSR_LANES;
    localparam int ENTRY_W = `BSR_BEATS * `BSR_DATA_W;

    logic [ENTRY_W-1:0] mem_r [DEPTH];
    logic [ENTRY_W-1:0] wr_flat;
    logic [NLANES-1:0]  sel_flat_n;

    assign wr_flat    = port_io.wr_data;
    assign sel_flat_n = port_io.wr_sel_n;

    // a deselected lane keeps its stored contents
    always_ff @(posedge core_clk_in) begin
        for (int i = 0; i < NLANES; i++) begin
            if (port_io.wr_req && !sel_flat_n[i]) begin
                mem_r[port_io.wr_addr][i*`BSR_LANE_W +: `BSR_LANE_W] <= wr_flat[i*`BSR_LANE_W +: `BSR_LANE_W];
            end
        end
    end

    // a read in the same cycle as a write to the same entry sees the old data
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            port_io.rd_data <= '0;
        end else if (port_io.rd_req) begin
            port_io.rd_data <= mem_r[port_io.rd_addr];
        end
    end
endmodule // burst_store

// ---- rtl/split_port_burst_sram_if.sv ----
// link-facing logic of the split-port burst memory
`timescale 1ns/10ps
`include "burst_sram_params.svh"

module split_port_burst_sram_if (
    input  wire logic                      core_clk_in,
    input  wire logic                      rst_in,
    input  wire logic                      link_clk_p_in,
    input  wire logic                      link_clk_n_in,
    input  wire logic                      pll_disable_n_in,
    input  wire logic                      read_port_select_n_in,
    input  wire logic                      write_port_select_n_in,
    input  wire logic [`BSR_ADDR_W-1:0]    address_in,
    input  wire logic [`BSR_DATA_W-1:0]    write_data_in,
    input  wire logic [`BSR_LANES-1:0]     byte_write_select_n_in,
    output logic      [`BSR_DATA_W-1:0]    read_data_out,
    output logic                           read_data_oe_n_out,
    output logic                           read_valid_flag_out,
    output logic                           echo_clock_out,
    output logic                           echo_clock_n_out
);
    // =========================================================
    // declarations
    // =========================================================
    logic                           lrst_meta_r;
    logic                           link_rst_r;
    logic                           pll_meta_r;
    logic                           pll_s2_r;
    logic                           pll_s3_r;
    logic                           latency_full_r;

    logic                           rd_take;
    logic [`BSR_AGE_DEPTH:1]        rd_age_r;
    burst_sram_pkg::addr_t          rd_addr_r;
    logic                           rd_tog_r;
    logic                           rd_pulse;

    logic                           wr_take;
    logic                           wr_second_r;
    logic                           wr_last_r;
    burst_sram_pkg::word_t          wr_even_r [2];
    burst_sram_pkg::lane_sel_t      wr_even_sel_r [2];
    burst_sram_pkg::word_t          wr_odd_r [2];
    burst_sram_pkg::lane_sel_t      wr_odd_sel_r [2];
    burst_sram_pkg::addr_t          wr_addr_r;
    logic                           wr_tog_r;
    logic                           wr_pulse;

    logic                           out_cap;
    logic                           out_sec;
    logic                           out_thr;
    burst_sram_pkg::burst_t         out_buf_r;
    logic                           out_first_r;
    logic                           out_second_r;
    burst_sram_pkg::word_t          q_p_r;
    logic                           valid_p_r;
    burst_sram_pkg::word_t          q_n_r;
    logic                           valid_n_r;

    store_port_if                   store_io ();

    // =========================================================
    // link reset and latency strap
    // =========================================================
    // the device has no reset pin; the core reset is carried into the
    // link domain, asserted at once and released on a positive edge
    always_ff @(posedge link_clk_p_in or posedge rst_in) begin
        if (rst_in) begin
            lrst_meta_r <= 1'b1;
            link_rst_r  <= 1'b1;
        end else begin
            lrst_meta_r <= 1'b0;
            link_rst_r  <= lrst_meta_r;
        end
    end

    always_ff @(posedge link_clk_p_in or posedge link_rst_r) begin
        if (link_rst_r) begin
            pll_meta_r <= 1'b1;
            pll_s2_r   <= 1'b1;
            pll_s3_r   <= 1'b1;
        end else begin
            pll_meta_r <= pll_disable_n_in;
            pll_s2_r   <= pll_meta_r;
            pll_s3_r   <= pll_s2_r;
        end
    end

    // the strap is meant to be static; changing it mid-read garbles that burst
    always_ff @(posedge link_clk_p_in or posedge link_rst_r) begin
        if (link_rst_r) begin
            latency_full_r <= 1'b1;
        end else if (pll_s2_r == pll_s3_r) begin
            latency_full_r <= pll_s3_r;
        end
    end

    // =========================================================
    // echo clocks
    // =========================================================
    assign echo_clock_out   = link_clk_p_in;
    assign echo_clock_n_out = link_clk_n_in;

    // =========================================================
    // read request capture (positive edge)
    // =========================================================
    // a burst occupies two cycles, so a select in the cycle after an
    // accepted read is not a new request
    assign rd_take = !read_port_select_n_in && !rd_age_r[1];

    always_ff @(posedge link_clk_p_in or posedge link_rst_r) begin
        if (link_rst_r) begin
            rd_age_r <= '0;
        end else begin
            rd_age_r <= {rd_age_r[`BSR_AGE_DEPTH-1:1], rd_take};
        end
    end

    // the address pins carry no fixed bit weight, any wiring order works
    always_ff @(posedge link_clk_p_in or posedge link_rst_r) begin
        if (link_rst_r) begin
            rd_addr_r <= `BSR_ADDR_RST;
            rd_tog_r  <= 1'b0;
        end else if (rd_take) begin
            rd_addr_r <= address_in;
            rd_tog_r  <= !rd_tog_r;
        end
    end

    // =========================================================
    // write request and data capture
    // =========================================================
    assign wr_take = !write_port_select_n_in && !wr_second_r;

    always_ff @(posedge link_clk_p_in or posedge link_rst_r) begin
        if (link_rst_r) begin
            wr_second_r <= 1'b0;
            wr_last_r   <= 1'b0;
        end else begin
            wr_second_r <= wr_take;
            wr_last_r   <= wr_second_r;
        end
    end

    // beats 0 and 2 land on positive edges, address with beat 2
    always_ff @(posedge link_clk_p_in or posedge link_rst_r) begin
        if (link_rst_r) begin
            wr_even_r[0]     <= `BSR_WORD_RST;
            wr_even_r[1]     <= `BSR_WORD_RST;
            wr_even_sel_r[0] <= `BSR_SEL_RST;
            wr_even_sel_r[1] <= `BSR_SEL_RST;
            wr_addr_r        <= `BSR_ADDR_RST;
        end else if (wr_take) begin
            wr_even_r[0]     <= write_data_in;
            wr_even_sel_r[0] <= byte_write_select_n_in;
        end else if (wr_second_r) begin
            wr_even_r[1]     <= write_data_in;
            wr_even_sel_r[1] <= byte_write_select_n_in;
            wr_addr_r        <= address_in;
        end
    end

    // beats 1 and 3 land on negative clock rising edges
    always_ff @(posedge link_clk_n_in or posedge link_rst_r) begin
        if (link_rst_r) begin
            wr_odd_r[0]     <= `BSR_WORD_RST;
            wr_odd_r[1]     <= `BSR_WORD_RST;
            wr_odd_sel_r[0] <= `BSR_SEL_RST;
            wr_odd_sel_r[1] <= `BSR_SEL_RST;
        end else if (wr_second_r) begin
            wr_odd_r[0]     <= write_data_in;
            wr_odd_sel_r[0] <= byte_write_select_n_in;
        end else if (wr_last_r) begin
            wr_odd_r[1]     <= write_data_in;
            wr_odd_sel_r[1] <= byte_write_select_n_in;
        end
    end

    always_ff @(posedge link_clk_n_in or posedge link_rst_r) begin
        if (link_rst_r) begin
            wr_tog_r <= 1'b0;
        end else if (wr_last_r) begin
            wr_tog_r <= !wr_tog_r;
        end
    end

    // =========================================================
    // crossing into the core domain
    // =========================================================
    // the burst words are held at least half a link cycle after the
    // toggle; the core clock is fast enough to copy them in that time
    event_crossing u_wr_cross (
        .dst_clk_in (core_clk_in),
        .rst_in     (rst_in),
        .toggle_in  (wr_tog_r),
        .pulse_out  (wr_pulse)
    );

    event_crossing u_rd_cross (
        .dst_clk_in (core_clk_in),
        .rst_in     (rst_in),
        .toggle_in  (rd_tog_r),
        .pulse_out  (rd_pulse)
    );

    assign store_io.wr_req      = wr_pulse;
    assign store_io.wr_addr     = wr_addr_r;
    assign store_io.wr_data[0]  = wr_even_r[0];
    assign store_io.wr_data[1]  = wr_odd_r[0];
    assign store_io.wr_data[2]  = wr_even_r[1];
    assign store_io.wr_data[3]  = wr_odd_r[1];
    assign store_io.wr_sel_n[0] = wr_even_sel_r[0];
    assign store_io.wr_sel_n[1] = wr_odd_sel_r[0];
    assign store_io.wr_sel_n[2] = wr_even_sel_r[1];
    assign store_io.wr_sel_n[3] = wr_odd_sel_r[1];
    assign store_io.rd_req      = rd_pulse;
    assign store_io.rd_addr     = rd_addr_r;

    burst_store u_store (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .port_io     (store_io.store)
    );

    // =========================================================
    // read launch schedule
    // =========================================================
    // the fetched burst settles in the core long before the capture
    // edge, and stays until the next read's fetch two cycles later
    assign out_cap = latency_full_r ? rd_age_r[2] : rd_age_r[1];
    assign out_sec = latency_full_r ? rd_age_r[3] : rd_age_r[2];
    assign out_thr = latency_full_r && rd_age_r[4];

    always_ff @(posedge link_clk_p_in or posedge link_rst_r) begin
        if (link_rst_r) begin
            out_buf_r <= '0;
        end else if (out_cap) begin
            out_buf_r <= store_io.rd_data;
        end
    end

    always_ff @(posedge link_clk_p_in or posedge link_rst_r) begin
        if (link_rst_r) begin
            out_first_r  <= 1'b0;
            out_second_r <= 1'b0;
        end else begin
            out_first_r  <= out_cap;
            out_second_r <= out_sec;
        end
    end

    // positive-edge beats: 0 and 2 at one-cycle latency, 1 and 3 at 2.5
    always_ff @(posedge link_clk_p_in or posedge link_rst_r) begin
        if (link_rst_r) begin
            q_p_r     <= `BSR_WORD_RST;
            valid_p_r <= 1'b0;
        end else begin
            valid_p_r <= (out_cap && !latency_full_r) || out_sec || out_thr;
            if (out_cap && !latency_full_r) begin
                q_p_r <= store_io.rd_data[0];
            end else if (out_sec) begin
                q_p_r <= latency_full_r ? out_buf_r[1] : out_buf_r[2];
            end else if (out_thr) begin
                q_p_r <= out_buf_r[3];
            end else begin
                q_p_r <= `BSR_WORD_RST;
            end
        end
    end

    // negative-edge beats fill the other half of each cycle
    always_ff @(posedge link_clk_n_in or posedge link_rst_r) begin
        if (link_rst_r) begin
            q_n_r     <= `BSR_WORD_RST;
            valid_n_r <= 1'b0;
        end else begin
            valid_n_r <= out_first_r || out_second_r;
            if (out_first_r) begin
                q_n_r <= latency_full_r ? out_buf_r[0] : out_buf_r[1];
            end else if (out_second_r) begin
                q_n_r <= latency_full_r ? out_buf_r[2] : out_buf_r[3];
            end else begin
                q_n_r <= `BSR_WORD_RST;
            end
        end
    end

    // =========================================================
    // double-rate output pins
    // =========================================================
    // each half of the clock shows the register launched by its edge
    assign read_data_out       = link_clk_p_in ? q_p_r : q_n_r;
    assign read_valid_flag_out = link_clk_p_in ? valid_p_r : valid_n_r;
    assign read_data_oe_n_out  = !read_valid_flag_out;

endmodule // split_port_burst_sram_if

// ---- test/sram_if_properties.sv ----
// pin-level concurrent checks of the split-port burst memory
`timescale 1ns/10ps
`include "burst_sram_params.svh"

module sram_if_properties (
    input  wire logic                   core_clk_in,
    input  wire logic                   rst_in,
    input  wire logic                   link_clk_p_in,
    input  wire logic                   link_clk_n_in,
    input  wire logic                   pll_disable_n_in,
    input  wire logic                   read_port_select_n_in,
    input  wire logic [`BSR_DATA_W-1:0] read_data_out,
    input  wire logic                   read_data_oe_n_out,
    input  wire logic                   read_valid_flag_out,
    input  wire logic                   echo_clock_out,
    input  wire logic                   echo_clock_n_out
);
    // ====================================================
    // read sequencing
    sequence s_read_taken;
        $fell(read_port_select_n_in);
    endsequence
    sequence s_two_beats;
        read_valid_flag_out ##1 read_valid_flag_out;
    endsequence
    // the strap is synced inside, so only a long-stable level fixes the latency
    lat_long_a: assert property (@(posedge link_clk_p_in) disable iff (rst_in)
        pll_disable_n_in [*8] ##0 s_read_taken |-> ##3 s_two_beats) else $error("long latency beats misplaced");
    lat_short_a: assert property (@(posedge link_clk_p_in) disable iff (rst_in)
        !pll_disable_n_in [*8] ##0 s_read_taken |-> ##2 s_two_beats) else $error("short latency beats misplaced");
    no_spurious_a: assert property (@(posedge link_clk_p_in) disable iff (rst_in)
        read_port_select_n_in [*4] |=> !read_valid_flag_out) else $error("valid without a read");
    burst_p_a: assert property (@(posedge link_clk_p_in) disable iff (rst_in)
        $rose(read_valid_flag_out) |=> read_valid_flag_out) else $error("burst cut short at positive edge");
    burst_n_a: assert property (@(posedge link_clk_n_in) disable iff (rst_in)
        $rose(read_valid_flag_out) |=> read_valid_flag_out) else $error("burst cut short at negative edge");
    // ====================================================
    // output release and echo clocks
    oe_valid_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        read_data_oe_n_out == !read_valid_flag_out) else $error("enable and valid disagree");
    idle_zero_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        !read_valid_flag_out |-> read_data_out == `BSR_WORD_RST) else $error("idle read data not cleared");
    echo_p_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        echo_clock_out == link_clk_p_in) else $error("echo clock off");
    echo_n_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        echo_clock_n_out == link_clk_n_in) else $error("inverse echo clock off");
endmodule // sram_if_properties

bind split_port_burst_sram_if sram_if_properties chk (
    .core_clk_in, .rst_in, .link_clk_p_in, .link_clk_n_in, .pll_disable_n_in, .read_port_select_n_in,
    .read_data_out, .read_data_oe_n_out, .read_valid_flag_out, .echo_clock_out, .echo_clock_n_out
);

// ---- test/sram_ctl_model.sv ----
// memory controller model driving both ports of the burst memory
`timescale 1ns/10ps
`include "burst_sram_params.svh"

module sram_ctl_model (
    input  wire logic                   link_clk_p_in,
    input  wire logic                   link_clk_n_in,
    output logic                        read_port_select_n_out,
    output logic                        write_port_select_n_out,
    output logic [`BSR_ADDR_W-1:0]      address_out,
    output logic [`BSR_DATA_W-1:0]      write_data_out,
    output logic [`BSR_LANES-1:0]       byte_write_select_n_out
);
    initial begin
        read_port_select_n_out  = 1'b1;
        write_port_select_n_out = 1'b1;
        address_out             = `BSR_ADDR_RST;
        write_data_out          = `BSR_WORD_RST;
        byte_write_select_n_out = `BSR_SEL_RST;
    end

    // ====================================================
    // one command slot; unused address slots, and data and lane selects after beat 3, show the inverse so a stale value never looks valid
    task automatic access(input logic do_rd, input burst_sram_pkg::addr_t ra, input logic do_wr,
                          input burst_sram_pkg::addr_t wa, input burst_sram_pkg::burst_t d,
                          input burst_sram_pkg::burst_sel_t s, input logic hold);
        @(posedge link_clk_p_in);
        #1;
        read_port_select_n_out  = !do_rd;
        write_port_select_n_out = !do_wr;
        address_out             = do_rd ? ra : ~address_out;
        write_data_out          = d[0];
        byte_write_select_n_out = s[0];
        @(posedge link_clk_p_in);
        #1;
        // a held select lands on the edge that the device must refuse
        read_port_select_n_out  = !(do_rd && hold);
        write_port_select_n_out = !(do_wr && hold);
        address_out             = ~address_out;
        write_data_out          = d[1];
        byte_write_select_n_out = s[1];
        @(posedge link_clk_n_in);
        #1;
        address_out             = do_wr ? wa : ~address_out;
        write_data_out          = d[2];
        byte_write_select_n_out = s[2];
        @(posedge link_clk_p_in);
        #1;
        read_port_select_n_out  = 1'b1;
        write_port_select_n_out = 1'b1;
        address_out             = ~address_out;
        write_data_out          = d[3];
        byte_write_select_n_out = s[3];
        @(posedge link_clk_n_in);
        #1;
        write_data_out          = ~write_data_out;
        byte_write_select_n_out = ~byte_write_select_n_out;
    endtask
endmodule // sram_ctl_model

// ---- test/testbench.sv ----
// self-checking bench of the split-port burst memory
`timescale 1ns/10ps
`include "burst_sram_params.svh"

module testbench;
    logic                          core_clk, rst, clk_p, clk_n, pll_n;
    logic                          rsel_n, wsel_n, oe_n, rvalid;
    logic [`BSR_ADDR_W-1:0]        addr;
    logic [`BSR_DATA_W-1:0]        wdata, rdata;
    logic [`BSR_LANES-1:0]         bws_n;
    int                            n_fail, checked;

    split_port_burst_sram_if uut (.core_clk_in(core_clk), .rst_in(rst), .link_clk_p_in(clk_p),
        .link_clk_n_in(clk_n), .pll_disable_n_in(pll_n), .read_port_select_n_in(rsel_n),
        .write_port_select_n_in(wsel_n), .address_in(addr), .write_data_in(wdata),
        .byte_write_select_n_in(bws_n), .read_data_out(rdata), .read_data_oe_n_out(oe_n),
        .read_valid_flag_out(rvalid), .echo_clock_out(), .echo_clock_n_out());
    sram_ctl_model ctl (.link_clk_p_in(clk_p), .link_clk_n_in(clk_n), .read_port_select_n_out(rsel_n),
        .write_port_select_n_out(wsel_n), .address_out(addr), .write_data_out(wdata),
        .byte_write_select_n_out(bws_n));

    always #4 core_clk = ~core_clk;
    always #80 begin
        clk_p = ~clk_p;
        clk_n = ~clk_p;
    end

    // ====================================================
    // shared checking and transfer tasks
    task automatic check(input burst_sram_pkg::word_t seen, input burst_sram_pkg::word_t exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // samples mid-half so the clock-level output mux has settled
    task automatic rd_check(input burst_sram_pkg::burst_t exp, input logic mode25);
        int   i;
        logic use_n;
        @(posedge clk_p);
        @(posedge clk_p);
        #40;
        check(burst_sram_pkg::word_t'(rvalid), `BSR_WORD_RST);
        if (mode25) repeat (2) @(posedge clk_p);
        for (i = 0; i < 5; i++) begin
            use_n = mode25 ? (i % 2 == 0) : (i % 2 == 1);
            if (use_n) @(posedge clk_n); else @(posedge clk_p);
            #40;
            if (i < 4) begin
                check(rdata, exp[i]);
                check(burst_sram_pkg::word_t'({rvalid, oe_n}), 18'h00002);
            end else begin
                check(rdata, `BSR_WORD_RST);
                check(burst_sram_pkg::word_t'({rvalid, oe_n}), 18'h00001);
            end
        end
    endtask

    // storage commit crosses clock domains, so each slot is followed by a gap
    task automatic op(input logic do_rd, input burst_sram_pkg::addr_t ra, input logic do_wr,
                      input burst_sram_pkg::addr_t wa, input burst_sram_pkg::burst_t d,
                      input burst_sram_pkg::burst_sel_t s, input burst_sram_pkg::burst_t exp,
                      input logic mode25);
        fork
            ctl.access(do_rd, ra, do_wr, wa, d, s, 1'b0);
            if (do_rd) rd_check(exp, mode25);
        join
        repeat (3) @(posedge clk_p);
    endtask

    // ====================================================
    // scenarios
    burst_sram_pkg::burst_t d1, d2, d3, e;
    localparam burst_sram_pkg::addr_t A1 = 19'h7ffff;
    localparam burst_sram_pkg::addr_t A2 = 19'h00001;

    task automatic t_idle;
        #40;
        check(rdata, `BSR_WORD_RST);
        check(burst_sram_pkg::word_t'({rvalid, oe_n}), 18'h00001);
        $display("test idle done");
    endtask

    task automatic t_write_read;
        op(1'b0, A2, 1'b1, A1, d1, 8'h00, d1, 1'b1);
        op(1'b1, A1, 1'b0, A2, d3, 8'hff, d1, 1'b1);
        $display("test write read done");
    endtask

    task automatic t_byte_lanes;
        int i;
        int l;
        burst_sram_pkg::burst_sel_t s;
        s = 8'he4;
        for (i = 0; i < 4; i++) begin
            for (l = 0; l < `BSR_LANES; l++) begin
                e[i][l*`BSR_LANE_W +: `BSR_LANE_W] = s[i][l] ? d1[i][l*`BSR_LANE_W +: `BSR_LANE_W]
                                                             : d2[i][l*`BSR_LANE_W +: `BSR_LANE_W];
            end
        end
        op(1'b0, A2, 1'b1, A1, d2, s, e, 1'b1);
        op(1'b1, A1, 1'b0, A2, d3, 8'hff, e, 1'b1);
        $display("test byte lanes done");
    endtask

    task automatic t_deselect;
        op(1'b0, A1, 1'b0, A1, d3, 8'h00, e, 1'b1);
        op(1'b1, A1, 1'b0, A2, d3, 8'h00, e, 1'b1);
        $display("test deselect done");
    endtask

    task automatic t_concurrent;
        op(1'b1, A1, 1'b1, A2, d3, 8'h00, e, 1'b1);
        op(1'b1, A2, 1'b0, A1, d1, 8'hff, d3, 1'b1);
        $display("test concurrent done");
    endtask

    task automatic t_short_latency;
        @(posedge clk_p);
        #1;
        pll_n = 1'b0;
        repeat (8) @(posedge clk_p);
        op(1'b1, A2, 1'b0, A1, d1, 8'hff, d3, 1'b0);
        @(posedge clk_p);
        #1;
        pll_n = 1'b1;
        repeat (8) @(posedge clk_p);
        op(1'b1, A1, 1'b0, A2, d1, 8'hff, e, 1'b1);
        $display("test latency modes done");
    endtask

    // selects held into the second cycle of an accepted access start nothing new
    task automatic t_refused;
        fork
            ctl.access(1'b1, A2, 1'b1, A2, d1, 8'h00, 1'b1);
            rd_check(d3, 1'b1);
        join
        repeat (3) @(posedge clk_p);
        op(1'b1, A2, 1'b0, A1, d2, 8'hff, d1, 1'b1);
        $display("test refused selects done");
    endtask

    initial begin
        core_clk = 1'b0;
        clk_p    = 1'b0;
        clk_n    = 1'b1;
        rst      = 1'b1;
        pll_n    = 1'b1;
        n_fail   = 0;
        checked  = 0;
        d1 = {18'h3ffff, 18'h00001, 18'h2aaaa, 18'h15555};
        d2 = {18'h12345, 18'h0f0f0, 18'h30c3c, 18'h2d2d2};
        d3 = {18'h1e1e1, 18'h00100, 18'h3c003, 18'h0abcd};
        repeat (16) @(posedge core_clk);
        repeat (3) @(posedge clk_p);
        #1;
        rst = 1'b0;
        repeat (4) @(posedge clk_p);
        t_idle();
        t_write_read();
        t_byte_lanes();
        t_deselect();
        t_concurrent();
        t_short_latency();
        t_refused();
        report_and_stop();
    end

    initial begin
        #200000;
        n_fail++;
        report_and_stop();
    end
endmodule // testbench
